// [design/imusc_core.sv]
/*
  imusc_core: system control and status registers of the inertial module:
  aux lines, data-ready and alarm indicators, self-test and flash test
  triggers, clear-on-read diagnostics, identification and static/dynamic alarms.
  assumes: one register access per request, already decoded by the serial
  interface; sample_tick pulses once all output words are fresh; inputs are
  synchronous to sys_clk.
*/
// Notes on behaviour
// - pin_io_control bits 3..0 set each aux line direction, 1 means output.
// - bits 11..8 drive output lines; reads return sampled level of input lines.
// - default: active-high data-ready pulse on aux line 0 once samples are fresh.
// - misc_control bit 2 enables indicator, bit 1 polarity, bit 0 picks line.
// - gyro linear-g bias compensation enabled only while misc_control bit 7 set.
// - accelerometer origin alignment enabled only while misc_control bit 6 set.
// - writing bit 10 starts self-test; bit clears when routine completes.
// - diag_flags bits 15..10 hold per-axis self-test failures.
// - writing bit 11 starts flash checksum; result in diag bit 6; bit self-clears.
// - every complete read of diag_flags clears its error flags except supply bits 1..0.
// - a persisting error condition sets its flag again next sample cycle.
// - diag_flags bit 9 shows alarm 2 active, bit 8 alarm 1 active.
// - diag bits 5,4,3,2: self-test error, overrange, serial fail, flash update.
// - diag bits 1..0 clear by themselves once supply is back in range.
// - read-only lot codes, fixed product code and unit serial number.
// - 16-bit counter of flash write cycles, read in flash_write_count XORed with FLASH_COUNT_INIT.
// - two alarms: thresholds 0x26/0x28, counts 0x2a/0x2c, config 0x2e.
// - alarm_config holds source select, mode, filtering and indicator control.
// - static mode compares selected source directly against its threshold.
// - threshold bit 15 is polarity: 1 above threshold, 0 below.
// - threshold is bits 13..0, bit 14 ignored, in source format.
// - line function priority: misc_control, then alarm_config, then pin_io_control.
// - alarm_config bit 2 enables indicator, bit 1 polarity, bit 0 picks line.
// - sample-count bits 7..0 give dynamic period; 0 and 1 both mean one.
`timescale 1ns/1ns

module imusc_core #(
  parameter logic [15:0] PRODUCT_CODE = 16'h5a5a, // arbitrary neutral value
  parameter logic [15:0] FLASH_COUNT_INIT = 16'h0000,
  parameter int DRDY_CYC = imusc_pkg::DRDY_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire imusc_pkg::imusc_access_t acc,
  output logic [15:0] acc_rdata,
  input wire logic sample_tick,
  input wire imusc_pkg::imusc_sample_t sample_raw,
  input wire imusc_pkg::imusc_sample_t sample_filt,
  input wire logic [3:0] aux_line_in,
  output logic [3:0] aux_line_out,
  output logic [3:0] aux_line_oe,
  output logic gyro_lin_g_comp_en,
  output logic accel_origin_align_en,
  output logic self_test_start,
  input wire logic self_test_done,
  input wire logic [5:0] self_test_fail,
  input wire logic self_test_diag_err,
  output logic flash_test_start,
  input wire logic flash_test_done,
  input wire logic flash_test_fail,
  input wire logic flash_write_done,
  input wire logic flash_update_fail,
  input wire logic spi_comm_fail,
  input wire logic overrange,
  input wire logic [1:0] supply_out_of_range,
  input wire logic [15:0] lot_code_first_in,
  input wire logic [15:0] lot_code_second_in,
  input wire logic [15:0] unit_serial_in
);

  // refused at elaboration: the pulse counter is only eight bits wide
  if (DRDY_CYC < 1 || DRDY_CYC > 255) begin : bad_drdy_cyc
    $error("imusc_core: DRDY_CYC must be 1..255");
  end

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [15:0] merge_be(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge_be = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic [15:0] pick_source(input logic [3:0] sel,
                                              input imusc_pkg::imusc_sample_t s);
    case (sel)
      4'h1: pick_source = s.gyro_x;
      4'h2: pick_source = s.gyro_y;
      4'h3: pick_source = s.gyro_z;
      4'h4: pick_source = s.accl_x;
      4'h5: pick_source = s.accl_y;
      4'h6: pick_source = s.accl_z;
      4'h7: pick_source = s.temp;
      default: pick_source = 16'h0000;
    endcase
  endfunction

  // polarity 1 trips above, 0 below; bit 14 is dropped
  function automatic logic trips(input logic [15:0] value, input logic [15:0] thr);
    logic signed [15:0] lim;
    lim = $signed({{2{thr[imusc_pkg::TH_VAL_MSB]}}, thr[imusc_pkg::TH_VAL_MSB:0]});
    trips = thr[imusc_pkg::TH_POL] ? ($signed(value) > lim) : ($signed(value) < lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] pin_io_control_reg;
  logic [15:0] misc_control_reg;
  logic [15:0] diag_flags_reg;
  logic [15:0] diag_flags_next;
  logic [15:0] alarm_threshold_reg [2];
  logic [15:0] alarm_sample_count_reg [2];
  logic [15:0] alarm_config_reg;
  logic [15:0] flash_write_count_reg;
  logic [5:0] st_fail_reg;
  logic st_diag_reg;
  logic flash_sum_fail_reg;
  logic [1:0] alarm_hit_reg;
  logic [7:0] drdy_cnt_reg;

  logic wr_pio, wr_misc, wr_cfg;
  logic [1:0] wr_thr, wr_cnt;
  logic [15:0] misc_wr_val;

  assign wr_pio = acc.wr && acc.addr == imusc_pkg::ADDR_PIN_IO_CONTROL;
  assign wr_misc = acc.wr && acc.addr == imusc_pkg::ADDR_MISC_CONTROL;
  assign wr_cfg = acc.wr && acc.addr == imusc_pkg::ADDR_ALARM_CONFIG;
  assign wr_thr[0] = acc.wr && acc.addr == imusc_pkg::ADDR_ALARM1_THRESHOLD;
  assign wr_thr[1] = acc.wr && acc.addr == imusc_pkg::ADDR_ALARM2_THRESHOLD;
  assign wr_cnt[0] = acc.wr && acc.addr == imusc_pkg::ADDR_ALARM1_SAMPLE_COUNT;
  assign wr_cnt[1] = acc.wr && acc.addr == imusc_pkg::ADDR_ALARM2_SAMPLE_COUNT;
  assign misc_wr_val = merge_be(misc_control_reg, acc.wdata, acc.be,
                                imusc_pkg::MASK_MISC_CONTROL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_io_control_reg <= imusc_pkg::RST_PIN_IO_CONTROL;
    end else if (wr_pio) begin
      // input-line levels are stored but never reach the pin
      pin_io_control_reg <= merge_be(pin_io_control_reg, acc.wdata, acc.be,
                                     imusc_pkg::MASK_PIN_IO_CONTROL);
    end
  end

  // trigger bits stay set until the engine reports completion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_control_reg <= imusc_pkg::RST_MISC_CONTROL;
      self_test_start <= 1'b0;
      flash_test_start <= 1'b0;
    end else begin
      self_test_start <= wr_misc && misc_wr_val[imusc_pkg::MC_SELF_TEST]
                         && !misc_control_reg[imusc_pkg::MC_SELF_TEST];
      flash_test_start <= wr_misc && misc_wr_val[imusc_pkg::MC_FLASH_TEST]
                          && !misc_control_reg[imusc_pkg::MC_FLASH_TEST];
      if (wr_misc) begin
        misc_control_reg <= misc_wr_val;
        // a running trigger cannot be cancelled by software
        if (misc_control_reg[imusc_pkg::MC_SELF_TEST]) begin
          misc_control_reg[imusc_pkg::MC_SELF_TEST] <= !self_test_done;
        end
        if (misc_control_reg[imusc_pkg::MC_FLASH_TEST]) begin
          misc_control_reg[imusc_pkg::MC_FLASH_TEST] <= !flash_test_done;
        end
      end else begin
        if (self_test_done) begin
          misc_control_reg[imusc_pkg::MC_SELF_TEST] <= 1'b0;
        end
        if (flash_test_done) begin
          misc_control_reg[imusc_pkg::MC_FLASH_TEST] <= 1'b0;
        end
      end
    end
  end

  assign gyro_lin_g_comp_en = misc_control_reg[imusc_pkg::MC_LIN_G_COMP];
  assign accel_origin_align_en = misc_control_reg[imusc_pkg::MC_ORIGIN_ALIGN];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_config_reg <= imusc_pkg::RST_ALARM_CONFIG;
      for (int i = 0; i < 2; i++) begin
        alarm_threshold_reg[i] <= imusc_pkg::RST_ALARM_THRESHOLD;
        alarm_sample_count_reg[i] <= imusc_pkg::RST_ALARM_SAMPLE_COUNT;
      end
    end else begin
      if (wr_cfg) begin
        alarm_config_reg <= merge_be(alarm_config_reg, acc.wdata, acc.be,
                                     imusc_pkg::MASK_ALARM_CONFIG);
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_thr[i]) begin
          alarm_threshold_reg[i] <= merge_be(alarm_threshold_reg[i], acc.wdata, acc.be,
                                             imusc_pkg::MASK_ALARM_THRESHOLD);
        end
        if (wr_cnt[i]) begin
          alarm_sample_count_reg[i] <= merge_be(alarm_sample_count_reg[i], acc.wdata,
                                                acc.be,
                                                imusc_pkg::MASK_ALARM_SAMPLE_COUNT);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_write_count_reg <= 16'h0000;
    end else if (flash_write_done) begin
      flash_write_count_reg <= flash_write_count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarms

  logic [15:0] alarm_src [2];
  logic [15:0] alarm_ref_reg [2];
  logic [15:0] alarm_delta_reg [2];
  logic [7:0] alarm_tick_cnt_reg [2];
  logic [1:0] alarm_cond;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      alarm_src[i] = pick_source(alarm_config_reg[imusc_pkg::AC_SRC1_LSB + 4 * i +: 4],
                                 alarm_config_reg[imusc_pkg::AC_FILTER] ? sample_filt
                                                                        : sample_raw);
      if (alarm_config_reg[imusc_pkg::AC_SRC1_LSB + 4 * i +: 4] == 4'h0 ||
          alarm_config_reg[imusc_pkg::AC_SRC1_LSB + 4 * i + 3]) begin
        alarm_cond[i] = 1'b0;
      end else if (alarm_config_reg[imusc_pkg::AC_DYN_LSB + i]) begin
        alarm_cond[i] = trips(alarm_delta_reg[i], alarm_threshold_reg[i]);
      end else begin
        alarm_cond[i] = trips(alarm_src[i], alarm_threshold_reg[i]);
      end
    end
  end

  // dynamic mode: change of the source across one period of samples
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        alarm_ref_reg[i] <= 16'h0000;
        alarm_delta_reg[i] <= 16'h0000;
        alarm_tick_cnt_reg[i] <= 8'h00;
      end
    end else if (sample_tick) begin
      for (int i = 0; i < 2; i++) begin
        if (alarm_tick_cnt_reg[i] + 8'h01 >= alarm_sample_count_reg[i][7:0]) begin
          alarm_tick_cnt_reg[i] <= 8'h00;
          alarm_delta_reg[i] <= alarm_src[i] - alarm_ref_reg[i];
          alarm_ref_reg[i] <= alarm_src[i];
        end else begin
          alarm_tick_cnt_reg[i] <= alarm_tick_cnt_reg[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_hit_reg <= 2'b00;
    end else if (sample_tick) begin
      alarm_hit_reg <= alarm_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostics

  logic diag_read;
  logic [15:0] diag_cond;
  logic [15:0] diag_event;

  assign diag_read = acc.rd && acc.addr == imusc_pkg::ADDR_DIAG_FLAGS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_fail_reg <= 6'b000000;
      st_diag_reg <= 1'b0;
      flash_sum_fail_reg <= 1'b0;
    end else begin
      if (self_test_done) begin
        st_fail_reg <= self_test_fail;
        st_diag_reg <= self_test_diag_err;
      end
      if (flash_test_done) begin
        flash_sum_fail_reg <= flash_test_fail;
      end
    end
  end

  // latched results keep re-asserting each sample until a test passes
  always_comb begin
    diag_cond = 16'h0000;
    diag_cond[imusc_pkg::DF_ST_AXIS_LSB +: 6] = st_fail_reg;
    diag_cond[imusc_pkg::DF_ALARM_LSB +: 2] = alarm_cond;
    diag_cond[imusc_pkg::DF_FLASH_SUM] = flash_sum_fail_reg;
    diag_cond[imusc_pkg::DF_ST_DIAG] = st_diag_reg;
    diag_cond[imusc_pkg::DF_OVERRANGE] = overrange;
    diag_event = 16'h0000;
    diag_event[imusc_pkg::DF_ST_AXIS_LSB +: 6] = self_test_done ? self_test_fail : 6'b000000;
    diag_event[imusc_pkg::DF_ST_DIAG] = self_test_done && self_test_diag_err;
    diag_event[imusc_pkg::DF_FLASH_SUM] = flash_test_done && flash_test_fail;
    diag_event[imusc_pkg::DF_SPI_FAIL] = spi_comm_fail;
    diag_event[imusc_pkg::DF_FLASH_UPD] = flash_update_fail;
    // set wins over the read clear
    diag_flags_next = (diag_read ? 16'h0000 : diag_flags_reg)
                      | (sample_tick ? diag_cond : 16'h0000) | diag_event;
    diag_flags_next[imusc_pkg::DF_SUPPLY_LSB +: 2] = supply_out_of_range;
    diag_flags_next[7] = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_flags_reg <= imusc_pkg::RST_DIAG_FLAGS;
    end else begin
      diag_flags_reg <= diag_flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aux lines

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drdy_cnt_reg <= 8'h00;
    end else if (sample_tick) begin
      drdy_cnt_reg <= DRDY_CYC[7:0];
    end else if (drdy_cnt_reg != 8'h00) begin
      drdy_cnt_reg <= drdy_cnt_reg - 8'h01;
    end
  end

  logic [3:0] line_out_next, line_oe_next;
  logic drdy_active;
  logic alarm_active;

  assign drdy_active = drdy_cnt_reg != 8'h00;
  assign alarm_active = |alarm_hit_reg;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (misc_control_reg[imusc_pkg::MC_IND_EN] &&
          k == int'(misc_control_reg[imusc_pkg::MC_IND_LINE])) begin
        line_oe_next[k] = 1'b1;
        line_out_next[k] = drdy_active ~^ misc_control_reg[imusc_pkg::MC_IND_POL];
      end else if (alarm_config_reg[imusc_pkg::AC_IND_EN] &&
                   k == int'(alarm_config_reg[imusc_pkg::AC_IND_LINE])) begin
        line_oe_next[k] = 1'b1;
        line_out_next[k] = alarm_active ~^ alarm_config_reg[imusc_pkg::AC_IND_POL];
      end else begin
        line_oe_next[k] = pin_io_control_reg[imusc_pkg::PIO_DIR_LSB + k];
        line_out_next[k] = pin_io_control_reg[imusc_pkg::PIO_LVL_LSB + k];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_line_out <= 4'h0;
      aux_line_oe <= 4'h0;
    end else begin
      aux_line_out <= line_out_next;
      aux_line_oe <= line_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [3:0] pio_level_view;
  logic [15:0] rdata_next;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pio_level_view[k] = pin_io_control_reg[imusc_pkg::PIO_DIR_LSB + k]
                          ? pin_io_control_reg[imusc_pkg::PIO_LVL_LSB + k]
                          : aux_line_in[k];
    end
    case (acc.addr)
      imusc_pkg::ADDR_FLASH_WRITE_COUNT: rdata_next = flash_write_count_reg ^ FLASH_COUNT_INIT;
      imusc_pkg::ADDR_ALARM1_THRESHOLD: rdata_next = alarm_threshold_reg[0];
      imusc_pkg::ADDR_ALARM2_THRESHOLD: rdata_next = alarm_threshold_reg[1];
      imusc_pkg::ADDR_ALARM1_SAMPLE_COUNT: rdata_next = alarm_sample_count_reg[0];
      imusc_pkg::ADDR_ALARM2_SAMPLE_COUNT: rdata_next = alarm_sample_count_reg[1];
      imusc_pkg::ADDR_ALARM_CONFIG: rdata_next = alarm_config_reg;
      imusc_pkg::ADDR_PIN_IO_CONTROL: rdata_next = {4'h0, pio_level_view, 4'h0,
                                                    pin_io_control_reg[3:0]};
      imusc_pkg::ADDR_MISC_CONTROL: rdata_next = misc_control_reg;
      imusc_pkg::ADDR_DIAG_FLAGS: rdata_next = diag_flags_reg;
      imusc_pkg::ADDR_LOT_CODE_FIRST: rdata_next = lot_code_first_in;
      imusc_pkg::ADDR_LOT_CODE_SECOND: rdata_next = lot_code_second_in;
      imusc_pkg::ADDR_PRODUCT_CODE: rdata_next = PRODUCT_CODE;
      imusc_pkg::ADDR_UNIT_SERIAL: rdata_next = unit_serial_in;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata <= 16'h0000;
    end else if (acc.rd) begin
      acc_rdata <= rdata_next;
    end
  end

endmodule

// [design/imusc_pkg.sv]
/*
  imusc_pkg: register map, field positions, reset values, timing counts
  and packed carriers for the system control and status register bank.
  assumes: 16-bit registers at their byte addresses on the serial access port.
*/
package imusc_pkg;

  // register addresses
  localparam logic [7:0] ADDR_FLASH_WRITE_COUNT = 8'h00;
  localparam logic [7:0] ADDR_ALARM1_THRESHOLD = 8'h26;
  localparam logic [7:0] ADDR_ALARM2_THRESHOLD = 8'h28;
  localparam logic [7:0] ADDR_ALARM1_SAMPLE_COUNT = 8'h2a;
  localparam logic [7:0] ADDR_ALARM2_SAMPLE_COUNT = 8'h2c;
  localparam logic [7:0] ADDR_ALARM_CONFIG = 8'h2e;
  localparam logic [7:0] ADDR_PIN_IO_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_MISC_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_DIAG_FLAGS = 8'h3c;
  localparam logic [7:0] ADDR_LOT_CODE_FIRST = 8'h52;
  localparam logic [7:0] ADDR_LOT_CODE_SECOND = 8'h54;
  localparam logic [7:0] ADDR_PRODUCT_CODE = 8'h56;
  localparam logic [7:0] ADDR_UNIT_SERIAL = 8'h58;

  // reset values
  localparam logic [15:0] RST_PIN_IO_CONTROL = 16'h0000;
  localparam logic [15:0] RST_MISC_CONTROL = 16'h0006;
  localparam logic [15:0] RST_DIAG_FLAGS = 16'h0000;
  localparam logic [15:0] RST_ALARM_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_ALARM_SAMPLE_COUNT = 16'h0000;
  localparam logic [15:0] RST_ALARM_CONFIG = 16'h0000;

  // writable bit masks
  localparam logic [15:0] MASK_PIN_IO_CONTROL = 16'h0f0f;
  localparam logic [15:0] MASK_MISC_CONTROL = 16'h0cc7;
  localparam logic [15:0] MASK_ALARM_THRESHOLD = 16'hbfff;
  localparam logic [15:0] MASK_ALARM_SAMPLE_COUNT = 16'h00ff;
  localparam logic [15:0] MASK_ALARM_CONFIG = 16'hffd7;

  // pin_io_control fields
  localparam int PIO_DIR_LSB = 0;
  localparam int PIO_LVL_LSB = 8;

  // misc_control fields
  localparam int MC_IND_LINE = 0;
  localparam int MC_IND_POL = 1;
  localparam int MC_IND_EN = 2;
  localparam int MC_ORIGIN_ALIGN = 6;
  localparam int MC_LIN_G_COMP = 7;
  localparam int MC_SELF_TEST = 10;
  localparam int MC_FLASH_TEST = 11;

  // alarm_config fields
  localparam int AC_IND_LINE = 0;
  localparam int AC_IND_POL = 1;
  localparam int AC_IND_EN = 2;
  localparam int AC_FILTER = 4;
  localparam int AC_DYN_LSB = 6;
  localparam int AC_SRC1_LSB = 8;
  localparam int AC_SRC2_LSB = 12;

  // alarm threshold fields
  localparam int TH_POL = 15;
  localparam int TH_VAL_MSB = 13;

  // diag_flags fields
  localparam int DF_SUPPLY_LSB = 0;
  localparam int DF_FLASH_UPD = 2;
  localparam int DF_SPI_FAIL = 3;
  localparam int DF_OVERRANGE = 4;
  localparam int DF_ST_DIAG = 5;
  localparam int DF_FLASH_SUM = 6;
  localparam int DF_ALARM_LSB = 8;
  localparam int DF_ST_AXIS_LSB = 10;

  // timing: data-ready pulse width
  localparam int CLK_HZ = 20_000_000;
  localparam int DRDY_PULSE_NS = 200;
  localparam int DRDY_PULSE_CYC = (DRDY_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // one set of output samples, signed 16-bit words
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] accl_z;
    logic [15:0] accl_y;
    logic [15:0] accl_x;
    logic [15:0] gyro_z;
    logic [15:0] gyro_y;
    logic [15:0] gyro_x;
  } imusc_sample_t;

  // register access request from the serial interface
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [1:0] be;
    logic [15:0] wdata;
    logic rd;
  } imusc_access_t;

endpackage

// [verif/imusc_core_asserts.sv]
/* imusc_core_asserts: port checks for imusc_core.
   assumes: bound to imusc_core, one clock, reset async low. */
`timescale 1ns/1ns
module imusc_core_asserts #(parameter logic [15:0] PRODUCT_CODE = 16'h5a5a) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire imusc_pkg::imusc_access_t acc,
  input wire logic [15:0] acc_rdata,
  input wire logic [3:0] aux_line_out,
  input wire logic [3:0] aux_line_oe,
  input wire logic gyro_lin_g_comp_en,
  input wire logic accel_origin_align_en,
  input wire logic self_test_start,
  input wire logic flash_test_start
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic wm;
  logic wp;
  assign wm = acc.wr && acc.addr == imusc_pkg::ADDR_MISC_CONTROL;
  // lines 3..2 only, so indicators never mask the check
  assign wp = acc.wr && acc.addr == imusc_pkg::ADDR_PIN_IO_CONTROL && acc.be == 2'h3;
  ////////////////////////////////////////
  chk_pio_dir: assert property (wp |-> ##2 aux_line_oe[3:2] == $past(acc.wdata[3:2], 2))
    else $error("aux direction wrong");
  chk_pio_level: assert property (wp && acc.wdata[3:2] == 2'h3
    |-> ##2 aux_line_out[3:2] == $past(acc.wdata[11:10], 2)) else $error("aux level wrong");
  chk_st_cause: assert property (self_test_start |-> $past(wm && acc.wdata[10]))
    else $error("self test start without trigger");
  chk_st_once: assert property (self_test_start |=> !self_test_start)
    else $error("self test start too long");
  chk_ft_cause: assert property (flash_test_start |-> $past(wm && acc.wdata[11]))
    else $error("flash test start without trigger");
  chk_comp_level: assert property (wm && acc.be[0]
    |=> gyro_lin_g_comp_en == $past(acc.wdata[7])) else $error("comp enable wrong");
  chk_align_level: assert property (wm && acc.be[0]
    |=> accel_origin_align_en == $past(acc.wdata[6])) else $error("align enable wrong");
  chk_prod_read: assert property (acc.rd && acc.addr == imusc_pkg::ADDR_PRODUCT_CODE
    |=> acc_rdata == PRODUCT_CODE) else $error("product code wrong");
  cover property (self_test_start);
  cover property (flash_test_start);
  cover property ($rose(aux_line_out[1]));
endmodule
bind imusc_core imusc_core_asserts #(.PRODUCT_CODE(PRODUCT_CODE)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .acc(acc), .acc_rdata(acc_rdata),
  .aux_line_out(aux_line_out), .aux_line_oe(aux_line_oe),
  .gyro_lin_g_comp_en(gyro_lin_g_comp_en), .accel_origin_align_en(accel_origin_align_en),
  .self_test_start(self_test_start), .flash_test_start(flash_test_start));

// [verif/imusc_host.sv]
/* imusc_host: host processor on the register access port.
   assumes: requests change at falling edges, taken at rising edges. */
`timescale 1ns/1ns
module imusc_host (
  input wire logic sys_clk,
  input wire logic [15:0] acc_rdata,
  output imusc_pkg::imusc_access_t acc
);
  initial acc = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    acc = '{addr: a, wr: 1'b1, be: 2'h3, wdata: d, rd: 1'b0};
    @(negedge sys_clk);
    acc.wr = 1'b0;
    // stale data must not pass for a valid word
    acc.wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    acc.addr = a;
    acc.rd = 1'b1;
    @(negedge sys_clk);
    acc.rd = 1'b0;
    @(negedge sys_clk);
    d = acc_rdata;
  endtask
endmodule

// [verif/tb.sv]
/* tb: self-checking bench for imusc_core.
   assumes: imusc_host drives accesses, bench drives the rest at falling edges. */
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] PC = 16'h5a5a; // arbitrary value
  localparam int DC = 4;
  logic sys_clk, rst_n, tick, st_done, st_derr, fl_done, fl_fail, fw_done, fu_fail, spi, ovr;
  logic [5:0] st_fail;
  logic [1:0] sup;
  logic [3:0] ain, aout, aoe;
  logic [15:0] rdat, lc, v;
  imusc_pkg::imusc_access_t acc;
  imusc_pkg::imusc_sample_t smp;
  int n_fail, num_checks;
  imusc_host host (.sys_clk(sys_clk), .acc_rdata(rdat), .acc(acc));
  imusc_core #(.PRODUCT_CODE(PC), .DRDY_CYC(DC)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .acc(acc), .acc_rdata(rdat), .sample_tick(tick), .sample_raw(smp), .sample_filt(smp),
    .aux_line_in(ain), .aux_line_out(aout), .aux_line_oe(aoe), .gyro_lin_g_comp_en(),
    .accel_origin_align_en(), .self_test_start(), .self_test_done(st_done),
    .self_test_fail(st_fail), .self_test_diag_err(st_derr), .flash_test_start(),
    .flash_test_done(fl_done), .flash_test_fail(fl_fail), .flash_write_done(fw_done),
    .flash_update_fail(fu_fail), .spi_comm_fail(spi), .overrange(ovr),
    .supply_out_of_range(sup), .lot_code_first_in(lc), .lot_code_second_in(~lc),
    .unit_serial_in(lc));
  ////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task end_sim;
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    logic [7:0] a[10];
    logic [15:0] e[10];
    a = '{8'h34, 8'h32, 8'h3c, 8'h26, 8'h2e, 8'h56, 8'h52, 8'h54, 8'h58, 8'h02};
    e = '{16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0000, PC, lc, ~lc, lc, 16'h0000};
    for (int i = 0; i < 10; i++) rchk(a[i], e[i]);
  endtask
  task t_pio;
    ain = 4'h2;
    host.wr(8'h32, 16'h080c);
    rchk(8'h32, 16'h0a0c);
    chk("oe", 16'h000d, 16'(aoe));
    chk("out", 16'h0002, 16'(aout[3:2]));
  endtask
  task t_drdy;
    pulse(tick);
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      chk("drdy", 16'(i < DC), 16'(aout[0]));
    end
    host.wr(8'h34, 16'h0005);
    cyc(2);
    chk("idle", 16'h0003, 16'({aoe[1], aout[1]}));
    pulse(tick);
    cyc(2);
    chk("act", 16'h0002, 16'({aoe[1], aout[1]}));
  endtask
  task t_diag;
    @(negedge sys_clk);
    {spi, fu_fail} = 2'h3;
    @(negedge sys_clk);
    {spi, fu_fail} = 2'h0;
    rchk(8'h3c, 16'h000c);
    rchk(8'h3c, 16'h0000);
    ovr = 1'b1;
    pulse(tick);
    rchk(8'h3c, 16'h0010);
    rchk(8'h3c, 16'h0000);
    pulse(tick);
    rchk(8'h3c, 16'h0010);
    ovr = 1'b0;
    sup = 2'h1;
    rchk(8'h3c, 16'h0001);
    sup = 2'h0;
    cyc(2);
    rchk(8'h3c, 16'h0000);
  endtask
  task t_test;
    host.wr(8'h34, 16'h0c06);
    rchk(8'h34, 16'h0c06);
    @(negedge sys_clk);
    {st_fail, st_derr, fl_fail, st_done, fl_done} = 10'h23f;
    @(negedge sys_clk);
    {st_done, fl_done} = 2'h0;
    rchk(8'h34, 16'h0006);
    rchk(8'h3c, 16'h8c60);
  endtask
  task t_alarm;
    host.wr(8'h34, 16'h00c0);
    host.wr(8'h2e, 16'h0107);
    host.wr(8'h26, 16'hc064);
    rchk(8'h26, 16'h8064);
    smp.gyro_x = 16'h00c8;
    pulse(tick);
    cyc(2);
    chk("alarm", 16'h0003, 16'({aoe[1], aout[1]}));
    rchk(8'h3c, 16'h8d60);
    host.wr(8'h26, 16'h0064);
    pulse(tick);
    cyc(2);
    chk("no alarm", 16'h0002, 16'({aoe[1], aout[1]}));
    // a drop of 200 trips only in dynamic mode; static value 0 stays above -100
    host.wr(8'h2e, 16'h0147);
    host.wr(8'h26, 16'h3f9c);
    smp.gyro_x = 16'h0000;
    pulse(tick);
    pulse(tick);
    cyc(2);
    chk("dyn alarm", 16'h0003, 16'({aoe[1], aout[1]}));
    pulse(fw_done);
    pulse(fw_done);
    rchk(8'h00, 16'h0002);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, tick, st_done, st_derr, fl_done, fl_fail, fw_done, fu_fail, spi, ovr} = '0;
    {st_fail, sup, ain, smp} = '0;
    lc = 16'h1234;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset;
    t_pio;
    t_drdy;
    t_diag;
    t_test;
    t_alarm;
    end_sim;
  end
  initial begin
    #1_000_000;
    n_fail++;
    end_sim;
  end
endmodule
